// ---- hw/csu_cfg.svh ----
/*
  Offsets, field positions, reset values, encodings and timing counts of
  the clock source unit. Assumes a 100 MHz system clock.
*/
`ifndef CSU_CFG_SVH
`define CSU_CFG_SVH

// Register byte offsets on the 32-bit bus
`define CSU_ADDR_W 4
`define CSU_OFF_CTRL_ONE 4'h0
`define CSU_OFF_CTRL_TWO 4'h4
`define CSU_OFF_OSC_ADJUST 4'h8
`define CSU_OFF_STATUS 4'hC

// Fields of clock_control_one
`define CSU_C1_SRC_HI 7
`define CSU_C1_SRC_LO 6
`define CSU_C1_REFERENCE_DIVIDER_HI 5
`define CSU_C1_REFERENCE_DIVIDER_LO 3
`define CSU_C1_REFERENCE_SELECT 2
`define CSU_C1_INTERNAL_REF_OUT_ENABLE 1
`define CSU_C1_INTERNAL_REF_STOP_ENABLE 0

// Fields of clock_control_two
`define CSU_C2_BUS_DIVIDER_HI 7
`define CSU_C2_BUS_DIVIDER_LO 6
`define CSU_C2_RANGE 5
`define CSU_C2_HGO 4
`define CSU_C2_LP 3
`define CSU_C2_EXTERNAL_REF_REQUEST 2
`define CSU_C2_EXTERNAL_REF_OUT_ENABLE 1
`define CSU_C2_EXTERNAL_REF_STOP_ENABLE 0

// Fields of clock_status_fine_adjust
`define CSU_SC_CLOCK_SOURCE_STATE_HI 3
`define CSU_SC_CLOCK_SOURCE_STATE_LO 2
`define CSU_SC_OSC_READY_FLAG 1
`define CSU_SC_OSC_FINE_ADJUST 0

// Reset values
`define CSU_RST_CTRL_ONE 8'h04
`define CSU_RST_CTRL_TWO 8'h40
`define CSU_RST_OSC_ADJUST 8'h80

// Source codes for the select field and the status field
`define CSU_SRC_LOOP 2'h0
`define CSU_SRC_INT 2'h1
`define CSU_SRC_EXT 2'h2
`define CSU_SRC_NONE 2'h3

// AXI responses
`define CSU_RESP_OKAY 2'h0
`define CSU_RESP_SLVERR 2'h2

// Loop multiplication and timing
`define CSU_LOOP_MULT 17'h00200
`define CSU_OSC_INIT_EDGES 13'h1000
`define CSU_CLK_PERIOD_NS 10
`define CSU_IRC_PERIOD_NS 30517
`define CSU_IRC_BASE_CYC (`CSU_IRC_PERIOD_NS / `CSU_CLK_PERIOD_NS)

`endif

// ---- hw/csu_pkg.sv ----
/*
  Types and shared decode functions of the clock source unit.
  Assumes csu_cfg.svh is on the include path.
*/
`include "csu_cfg.svh"

package csu_pkg;

  typedef logic [`CSU_ADDR_W-1:0] csu_addr_t;
  typedef logic [1:0] csu_src_t;
  typedef logic [2:0] csu_divsel_t;

  typedef enum logic [1:0] {OSC_OFF, OSC_STARTING, OSC_READY} csu_osc_e;

  typedef struct packed {
    logic [6:0] count;
  } csu_div_s;

  typedef struct packed {
    logic [7:0] ctrlOne;
    logic [7:0] ctrlTwo;
    logic [7:0] oscAdjust;
    logic fineAdjust;
    logic awHeld;
    csu_addr_t awAddr;
    logic wHeld;
    logic [7:0] wData;
    logic wStrb0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
    logic extSync1;
    logic extSync2;
    logic extPrev;
    csu_osc_e oscState;
    logic [12:0] oscCount;
    logic [11:0] intCount;
    logic [15:0] refMeasure;
    logic [15:0] refPeriod;
    logic [16:0] loopAcc;
    logic loopOn;
    csu_src_t curSrc;
    logic busClk;
    logic intOut;
    logic extOut;
  } csu_state_s;

  // All-ones mask of a power-of-two divider: 1, 2, 4 ... 128
  function automatic logic [6:0] csu_pow2_mask(input csu_divsel_t sel);
    csu_pow2_mask = 7'(8'h01 << sel) - 7'h01;
  endfunction

  // True for an offset that holds a register
  function automatic logic csu_mapped(input csu_addr_t addr);
    csu_mapped = (addr == `CSU_OFF_CTRL_ONE) || (addr == `CSU_OFF_CTRL_TWO) ||
      (addr == `CSU_OFF_OSC_ADJUST) || (addr == `CSU_OFF_STATUS);
  endfunction

endpackage

// ---- hw/csu_tick_div.sv ----
/*
  Power-of-two divider of a stream of one-cycle clock ticks.
  Assumes ticks and clear come from logic on the same clock.
*/
`include "csu_cfg.svh"

module csu_tick_div (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic clear,
  input wire logic tickIn,
  input wire csu_pkg::csu_divsel_t divSel,
  output logic tickOut
);
  import csu_pkg::*;

  csu_div_s s_q;
  csu_div_s s_d;
  logic hit;

  // One tick out for every 2**divSel ticks in; clear restarts a full count
  always_comb begin
    s_d = s_q;
    hit = (s_q.count >= csu_pow2_mask(divSel));
    tickOut = tickIn && !clear && hit;
    if (clear) begin
      s_d.count = 7'h00;
    end else if (tickIn) begin
      s_d.count = hit ? 7'h00 : s_q.count + 7'h01;
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else if (clockEnable) begin
      s_q <= s_d;
    end
  end

endmodule // csu_tick_div

// ---- hw/csu_clock_source.sv ----
/*
  Clock source unit: picks the bus clock from a frequency-locked loop,
  the external reference or the internal reference, divides and halves
  it. Registers are reached over AXI4-Lite.
  Assumes the external reference arrives as an asynchronous pin well
  below half the system clock, and the system clock runs at 100 MHz.
*/
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
// What this block does
// - Select field 00 routes the loop output, 10 the external reference.
// - Reference divider 111 divides the loop reference by 128.
// - Reference select 0 feeds the loop from the external reference.
// - Internal reference stops in stop mode when its stop enable is 0.
// - Bus divider 01 divides the selected clock by two.
// - Band bit 1 puts the external oscillator in its high range.
// - Gain bit 1 selects high gain, 0 reduced-amplitude low power.
// - Loop power-down 0 keeps the loop running while bypassed.
// - External reference stops in stop mode when its stop enable is 0.
// - Engaged: loop multiplies divided reference by 512, bus divider, halve.
// - Bypassed external: bus clock is reference over bus divider over two.
// - Ready flag sets after crystal start-up; software polls it.
// - Higher adjust value gives a slower internal reference.
// - Request bit 1 asks for the crystal oscillator, 0 an external clock.
// - Power-down 1 in bypass stops the loop unless debug mode is active.
`include "csu_cfg.svh"

module csu_clock_source (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic awvalid,
  output logic awready,
  input wire csu_pkg::csu_addr_t awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire csu_pkg::csu_addr_t araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic extRefPin,
  input wire logic stopMode,
  input wire logic bdmActive,
  output logic busClock,
  output logic loopEnable,
  output logic oscEnable,
  output logic oscRangeHigh,
  output logic oscHighGain,
  output logic oscCrystalReq,
  output logic internalRefClockOut,
  output logic externalRefClockOut
);
  import csu_pkg::*;

  csu_state_s s_q;
  csu_state_s s_d;

  csu_src_t reqSrc;
  csu_divsel_t refDivSel;
  csu_divsel_t busDivSel;
  logic extEdge;
  logic extTick;
  logic oscReady;
  logic oscWanted;
  logic intRun;
  logic intTick;
  logic refTick;
  logic divRefTick;
  logic loopTick;
  logic loopWanted;
  logic selTick;
  logic busTick;
  logic srcReady;
  logic switchNow;
  logic [16:0] accSum;
  logic [12:0] oscLimit;
  logic [11:0] intReload;
  logic doWrite;
  logic [7:0] readByte;

  // Handshake outputs; a frozen block takes no transfer
  assign awready = clockEnable && !s_q.awHeld && !s_q.bValid;
  assign wready = clockEnable && !s_q.wHeld && !s_q.bValid;
  assign arready = clockEnable && !s_q.rValid;
  assign bvalid = s_q.bValid;
  assign bresp = s_q.bResp;
  assign rvalid = s_q.rValid;
  assign rdata = {24'h000000, s_q.rData};
  assign rresp = s_q.rResp;

  // Pad controls and clocks straight from flops; oscEnable decodes the oscillator state
  assign busClock = s_q.busClk;
  assign loopEnable = s_q.loopOn;
  assign oscEnable = (s_q.oscState != OSC_OFF);
  assign oscRangeHigh = s_q.ctrlTwo[`CSU_C2_RANGE];
  assign oscHighGain = s_q.ctrlTwo[`CSU_C2_HGO];
  assign oscCrystalReq = s_q.ctrlTwo[`CSU_C2_EXTERNAL_REF_REQUEST];
  assign internalRefClockOut = s_q.intOut;
  assign externalRefClockOut = s_q.extOut;

  // Field decode of the control registers
  assign reqSrc = s_q.ctrlOne[`CSU_C1_SRC_HI:`CSU_C1_SRC_LO];
  assign refDivSel = s_q.ctrlOne[`CSU_C1_REFERENCE_DIVIDER_HI:`CSU_C1_REFERENCE_DIVIDER_LO];
  assign busDivSel = {1'b0, s_q.ctrlTwo[`CSU_C2_BUS_DIVIDER_HI:`CSU_C2_BUS_DIVIDER_LO]};

  // Rising edge of the synchronised pin; the first stage is not looked at
  assign extEdge = s_q.extSync2 && !s_q.extPrev;
  assign oscReady = (s_q.oscState == OSC_READY);
  assign extTick = extEdge && oscReady;

  // Oscillator runs while anything uses it, and in stop only if allowed
  assign oscWanted = (s_q.ctrlTwo[`CSU_C2_EXTERNAL_REF_REQUEST] ||
    s_q.ctrlTwo[`CSU_C2_EXTERNAL_REF_OUT_ENABLE] || !s_q.ctrlOne[`CSU_C1_REFERENCE_SELECT] ||
    reqSrc == `CSU_SRC_EXT || s_q.curSrc == `CSU_SRC_EXT) &&
    (!stopMode || s_q.ctrlTwo[`CSU_C2_EXTERNAL_REF_STOP_ENABLE]);

  // A crystal needs its start-up edges; a driven clock needs only one
  assign oscLimit = s_q.ctrlTwo[`CSU_C2_EXTERNAL_REF_REQUEST] ?
    `CSU_OSC_INIT_EDGES : 13'h0001;

  // Internal reference runs while used, and in stop only if allowed
  assign intRun = (s_q.ctrlOne[`CSU_C1_INTERNAL_REF_OUT_ENABLE] ||
    s_q.ctrlOne[`CSU_C1_REFERENCE_SELECT] || reqSrc == `CSU_SRC_INT ||
    s_q.curSrc == `CSU_SRC_INT) &&
    (!stopMode || s_q.ctrlOne[`CSU_C1_INTERNAL_REF_STOP_ENABLE]);
  assign intTick = intRun && (s_q.intCount == 12'h000);

  // A larger adjust value lengthens the period, so the reference slows
  assign intReload = 12'(`CSU_IRC_BASE_CYC) + {4'h0, s_q.oscAdjust} +
    {11'h000, s_q.fineAdjust};

  // Loop reference: internal when the select bit is 1, else external
  assign refTick = s_q.ctrlOne[`CSU_C1_REFERENCE_SELECT] ? intTick : extTick;

  // Reference divider, 2**field, so 111 divides by 128
  csu_tick_div refDivider (
    .clock(clock),
    .rst(rst),
    .clockEnable(clockEnable),
    .clear(1'b0),
    .tickIn(refTick),
    .divSel(refDivSel),
    .tickOut(divRefTick)
  );

  // Loop off in stop, and in bypass with power-down set unless debugging
  assign loopWanted = !stopMode && !(s_q.ctrlTwo[`CSU_C2_LP] &&
    reqSrc != `CSU_SRC_LOOP && s_q.curSrc != `CSU_SRC_LOOP &&
    !bdmActive);

  // The loop emits 512 ticks per measured divided-reference period
  assign accSum = s_q.loopAcc + `CSU_LOOP_MULT;
  assign loopTick = s_q.loopOn && (s_q.refPeriod != 16'h0000) &&
    (accSum >= {1'b0, s_q.refPeriod});

  // Tick stream of the source that drives the bus path now
  always_comb begin
    case (s_q.curSrc)
      `CSU_SRC_LOOP: selTick = loopTick;
      `CSU_SRC_INT: selTick = intTick;
      `CSU_SRC_EXT: selTick = extTick;
      default: selTick = 1'b0;
    endcase
  end

  // A switch waits for a low bus phase; one to the external reference also waits for the oscillator to be ready
  assign srcReady = (reqSrc != `CSU_SRC_EXT) || oscReady;
  assign switchNow = (reqSrc != `CSU_SRC_NONE) && (reqSrc != s_q.curSrc) &&
    srcReady && !s_q.busClk;

  // Bus divider restarts on a switch, so the low phase is never cut short
  csu_tick_div busDivider (
    .clock(clock),
    .rst(rst),
    .clockEnable(clockEnable),
    .clear(switchNow),
    .tickIn(selTick && !stopMode),
    .divSel(busDivSel),
    .tickOut(busTick)
  );

  // Write happens once both address and data are held
  assign doWrite = s_q.awHeld && s_q.wHeld && !s_q.bValid;

  // Read data of every register; unused bits read as zero
  always_comb begin
    case (araddr)
      `CSU_OFF_CTRL_ONE: readByte = s_q.ctrlOne;
      `CSU_OFF_CTRL_TWO: readByte = s_q.ctrlTwo;
      `CSU_OFF_OSC_ADJUST: readByte = s_q.oscAdjust;
      `CSU_OFF_STATUS: readByte = {4'h0, s_q.curSrc, oscReady,
        s_q.fineAdjust};
      default: readByte = 8'h00;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    s_d = s_q;

    // Write address and data channels, taken in either order
    if (awvalid && awready) begin
      s_d.awHeld = 1'b1;
      s_d.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.wHeld = 1'b1;
      s_d.wData = wdata[7:0];
      s_d.wStrb0 = wstrb[0];
    end

    // Register write; only the low byte lane carries register bits
    if (doWrite) begin
      s_d.awHeld = 1'b0;
      s_d.wHeld = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = csu_mapped(s_q.awAddr) ? `CSU_RESP_OKAY : `CSU_RESP_SLVERR;
      if (s_q.wStrb0) begin
        case (s_q.awAddr)
          `CSU_OFF_CTRL_ONE: s_d.ctrlOne = s_q.wData;
          `CSU_OFF_CTRL_TWO: s_d.ctrlTwo = s_q.wData;
          `CSU_OFF_OSC_ADJUST: s_d.oscAdjust = s_q.wData;
          `CSU_OFF_STATUS: s_d.fineAdjust = s_q.wData[`CSU_SC_OSC_FINE_ADJUST];
          default: s_d.bResp = `CSU_RESP_SLVERR;
        endcase
      end
    end
    if (s_q.bValid && bready) begin
      s_d.bValid = 1'b0;
    end

    // Read channel: data is captured at the edge that takes the address
    if (arvalid && arready) begin
      s_d.rValid = 1'b1;
      s_d.rData = readByte;
      s_d.rResp = csu_mapped(araddr) ? `CSU_RESP_OKAY : `CSU_RESP_SLVERR;
    end else if (s_q.rValid && rready) begin
      s_d.rValid = 1'b0;
    end

    // Two-flop synchroniser and edge history of the reference pin
    s_d.extSync1 = extRefPin;
    s_d.extSync2 = s_q.extSync1;
    s_d.extPrev = s_q.extSync2;

    // Oscillator start-up: count reference edges until ready
    if (!oscWanted) begin
      s_d.oscState = OSC_OFF;
      s_d.oscCount = 13'h0000;
    end else begin
      case (s_q.oscState)
        OSC_OFF: begin
          s_d.oscState = OSC_STARTING;
          s_d.oscCount = 13'h0000;
        end
        OSC_STARTING: begin
          if (extEdge) begin
            s_d.oscCount = s_q.oscCount + 13'h0001;
            if (s_q.oscCount + 13'h0001 >= oscLimit) begin
              s_d.oscState = OSC_READY;
            end
          end
        end
        OSC_READY: s_d.oscState = OSC_READY;
        default: s_d.oscState = OSC_OFF;
      endcase
    end

    // Internal reference period counter
    if (!intRun) begin
      s_d.intCount = intReload;
    end else if (intTick) begin
      s_d.intCount = intReload - 12'h001;
    end else begin
      s_d.intCount = s_q.intCount - 12'h001;
    end

    // Measure the divided reference in system cycles; no ticks, no lock
    if (divRefTick) begin
      s_d.refPeriod = s_q.refMeasure + 16'h0001;
      s_d.refMeasure = 16'h0000;
    end else if (s_q.refMeasure == 16'hFFFF) begin
      s_d.refPeriod = 16'h0000;
    end else begin
      s_d.refMeasure = s_q.refMeasure + 16'h0001;
    end

    // Loop phase accumulator; a disabled loop restarts from zero
    s_d.loopOn = loopWanted;
    if (!s_q.loopOn) begin
      s_d.loopAcc = 17'h00000;
    end else if (loopTick) begin
      s_d.loopAcc = (accSum >= {s_q.refPeriod, 1'b0}) ?
        17'h00000 : accSum - {1'b0, s_q.refPeriod};
    end else begin
      s_d.loopAcc = accSum;
    end

    // Source switch and bus clock halving stage
    if (switchNow) begin
      s_d.curSrc = reqSrc;
    end else if (busTick) begin
      s_d.busClk = !s_q.busClk;
    end

    // Reference clock outputs follow their enables and stop settings
    if (intTick && s_q.ctrlOne[`CSU_C1_INTERNAL_REF_OUT_ENABLE]) begin
      s_d.intOut = !s_q.intOut;
    end
    if (extTick && s_q.ctrlTwo[`CSU_C2_EXTERNAL_REF_OUT_ENABLE]) begin
      s_d.extOut = !s_q.extOut;
    end
  end

  // State register; reset values are constants, the enable freezes all
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctrlOne <= `CSU_RST_CTRL_ONE;
      s_q.ctrlTwo <= `CSU_RST_CTRL_TWO;
      s_q.oscAdjust <= `CSU_RST_OSC_ADJUST;
      s_q.oscState <= OSC_OFF;
      s_q.curSrc <= `CSU_SRC_LOOP;
      s_q.loopOn <= 1'b1;
    end else if (clockEnable) begin
      s_q <= s_d;
    end
  end

endmodule // csu_clock_source

// ---- tb/csu_ext_ref_model.sv ----
/*
  Behavioural external reference driving extRefPin.
  Assumes the bench keeps it running while the oscillator is wanted.
*/
module csu_ext_ref_model #(
  parameter int HALF_NS = 100
) (
  input wire logic run,
  output logic extRefPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Odd offset keeps pin edges away from system clock edges
  // A stopped source stands still instead of toggling
  initial begin
    extRefPin = 1'b0;
    #3;
    forever begin
      #(HALF_NS);
      if (run) extRefPin = !extRefPin;
    end
  end
endmodule // csu_ext_ref_model

// ---- tb/csu_clock_source_props.sv ----
/*
  Port checker of the clock source unit.
  Assumes one clock domain; bound to every top instance below.
*/
module csu_clock_source_props (
  input wire logic clock,
  input wire logic rst,
  input wire logic clockEnable,
  input wire logic awready,
  input wire logic wready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic stopMode,
  input wire logic bdmActive,
  input wire logic busClock,
  input wire logic loopEnable
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Debug held long enough for the loop enable to settle
  sequence s_dbg;
    (bdmActive && !stopMode && clockEnable) [*3];
  endsequence
  property p_ce; !clockEnable |-> !awready && !wready && !arready; endproperty
  property p_wr; bvalid |-> !awready && !wready; endproperty
  property p_bh; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  property p_rh;
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
  endproperty
  property p_ar;
    arvalid && arready |=> rvalid && !arready && rdata[31:8] == 24'h000000;
  endproperty
  property p_frz; !clockEnable |=> $stable(busClock); endproperty
  property p_stop; stopMode |=> $stable(busClock) && !loopEnable; endproperty
  property p_dbg; s_dbg |-> loopEnable; endproperty
  a_ce: assert property (p_ce) else $error("ready while frozen");
  a_wr: assert property (p_wr) else $error("write ready with response");
  a_bh: assert property (p_bh) else $error("write response dropped");
  a_rh: assert property (p_rh) else $error("read response dropped");
  a_ar: assert property (p_ar) else $error("read answer wrong");
  a_frz: assert property (p_frz) else $error("bus clock ran frozen");
  a_stop: assert property (p_stop) else $error("clock ran in stop");
  a_dbg: assert property (p_dbg) else $error("loop off in debug");
endmodule // csu_clock_source_props

bind csu_clock_source csu_clock_source_props csu_clock_source_props_i (
  .clock, .rst, .clockEnable, .awready, .wready, .arvalid, .arready,
  .bvalid, .bready, .bresp, .rvalid, .rready, .rdata, .rresp, .stopMode,
  .bdmActive, .busClock, .loopEnable);

// ---- tb/csu_clock_source_tb.sv ----
/*
  Self-checking bench of the clock source unit over AXI4-Lite.
  Assumes csu_cfg.svh on the include path and a 5 MHz reference.
*/
`include "csu_cfg.svh"
module csu_clock_source_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import csu_pkg::*;
  logic clock = 0, rst = 1, clockEnable = 1, awvalid = 0, wvalid = 0;
  logic bready = 0, arvalid = 0, rready = 0, stopMode = 0, bdmActive = 0;
  csu_addr_t awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0] wstrb = '0;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, extRefPin, busClock;
  logic loopEnable, oscEnable, oscRangeHigh, oscHighGain, oscCrystalReq;
  logic internalRefClockOut, externalRefClockOut;
  int error_cnt = 0, num_checks = 0;

  csu_clock_source csu_clock_source_i (.clock, .rst, .clockEnable,
    .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .extRefPin, .stopMode, .bdmActive,
    .busClock, .loopEnable, .oscEnable, .oscRangeHigh, .oscHighGain,
    .oscCrystalReq, .internalRefClockOut, .externalRefClockOut);
  // 5 MHz over 128 gives 39.0625 kHz
  csu_ext_ref_model #(.HALF_NS(100)) csu_ext_ref_model_i (
    .run(oscEnable || !oscCrystalReq), .extRefPin);

  // System clock, 100 MHz
  always #5 clock = !clock;

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      error_cnt++;
      $display("BAD %0t seen %h want %h", $time, s, x);
    end
  endtask

  // Write: address and data offered together, bready raised late
  task automatic wr(input csu_addr_t a, input logic [7:0] d,
      input logic [1:0] e = `CSU_RESP_OKAY);
    logic [1:0] p, t;
    awaddr <= a; wdata <= {24'h000000, d}; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; p = 2'b11;
    while (p != 2'b00) begin
      @(negedge clock);
      t = p & {awready, wready};
      @(posedge clock);
      if (t[1]) awvalid <= 1'b0;
      if (t[0]) wvalid <= 1'b0;
      p = p & ~t;
    end
    do @(negedge clock); while (bvalid !== 1'b1);
    @(posedge clock) bready <= 1'b1;
    // Response is taken at the edge that sees bready and bvalid high
    @(negedge clock) chk(bresp, e);
    @(posedge clock) bready <= 1'b0;
  endtask

  task automatic rd(input csu_addr_t a, output logic [7:0] d,
      input logic [1:0] e = `CSU_RESP_OKAY);
    araddr <= a; arvalid <= 1'b1;
    do @(negedge clock); while (arready !== 1'b1);
    @(posedge clock) arvalid <= 1'b0;
    do @(negedge clock); while (rvalid !== 1'b1);
    @(posedge clock) rready <= 1'b1;
    // Data and response taken at the falling edge before the read handshake
    @(negedge clock) chk(rresp, e);
    d = rdata[7:0];
    @(posedge clock) rready <= 1'b0;
  endtask

  task automatic rc(input csu_addr_t a, input logic [7:0] m, x);
    logic [7:0] d;
    rd(a, d);
    chk(d & m, x);
  endtask

  // Bounded status poll, as software would spin on it
  task automatic poll(input logic [7:0] m, x);
    logic [7:0] d;
    int k;
    k = 0;
    do begin
      rd(`CSU_OFF_STATUS, d);
      k++;
    end while ((d & m) !== x && k < 400);
    chk(d & m, x);
  endtask

  function automatic logic pick(input int s);
    if (s == 0) return busClock;
    if (s == 1) return internalRefClockOut;
    return externalRefClockOut;
  endfunction

  task automatic cnt(input int s, input int c, output int n);
    logic p;
    n = 0;
    @(negedge clock);
    p = pick(s);
    repeat (c) begin
      @(negedge clock);
      if (pick(s) !== p) n++;
      p = pick(s);
    end
  endtask

  // Cycles between two toggles, after a first toggle
  task automatic gap(input int s, output int g);
    logic p;
    repeat (2) begin
      p = pick(s);
      g = 0;
      while (pick(s) === p && g < 20000) begin
        @(negedge clock);
        g++;
      end
    end
  endtask

  // Default mode runs the loop at once, but with no measured reference period yet the bus clock is still low at release
  task automatic t_reset;
    logic [7:0] d;
    chk(busClock, 0);
    chk(oscEnable, 0);
    rc(`CSU_OFF_CTRL_ONE, 8'hFF, `CSU_RST_CTRL_ONE);
    rc(`CSU_OFF_CTRL_TWO, 8'hFF, `CSU_RST_CTRL_TWO);
    rc(`CSU_OFF_OSC_ADJUST, 8'hFF, `CSU_RST_OSC_ADJUST);
    rc(`CSU_OFF_STATUS, 8'hFF, 8'h00);
    rd(4'h2, d, `CSU_RESP_SLVERR);
    wr(4'h2, 8'h55, `CSU_RESP_SLVERR);
    $display("reset test done");
  endtask

  task automatic t_osc;
    wr(`CSU_OFF_CTRL_TWO, 8'h74);
    repeat (2) @(negedge clock);
    chk(oscRangeHigh, 1);
    chk(oscHighGain, 1);
    chk(oscCrystalReq, 1);
    @(posedge clock);
    wr(`CSU_OFF_CTRL_TWO, 8'h62);
    repeat (2) @(negedge clock);
    chk(oscHighGain, 0);
    chk(oscCrystalReq, 0);
    @(posedge clock);
    rc(`CSU_OFF_CTRL_TWO, 8'hFF, 8'h62);
    poll(8'h02, 8'h02);
    $display("oscillator test done");
  endtask

  task automatic t_fbe;
    int g;
    wr(`CSU_OFF_CTRL_ONE, 8'hB8);
    poll(8'h0C, 8'h08);
    gap(0, g);
    chk(g, 40);
    chk(loopEnable, 1);
    @(posedge clock);
    wr(`CSU_OFF_CTRL_TWO, 8'h6A);
    repeat (3) @(negedge clock);
    chk(loopEnable, 0);
    @(posedge clock) bdmActive <= 1'b1;
    repeat (3) @(negedge clock);
    chk(loopEnable, 1);
    @(posedge clock) bdmActive <= 1'b0;
    wr(`CSU_OFF_CTRL_TWO, 8'h62);
    $display("bypassed test done");
  endtask

  // Loop: 512 ticks per 2560 cycles, two ticks per toggle
  task automatic t_fee;
    int n;
    wr(`CSU_OFF_CTRL_ONE, 8'h38);
    poll(8'h0C, 8'h00);
    repeat (6000) @(posedge clock);
    cnt(0, 12800, n);
    chk(n > 1275 && n < 1285, 1);
    $display("engaged test done");
  endtask

  task automatic t_stop;
    int n;
    cnt(2, 200, n);
    chk(n > 8 && n < 12, 1);
    @(posedge clock) clockEnable <= 1'b0;
    cnt(0, 50, n);
    chk(n, 0);
    @(posedge clock) clockEnable <= 1'b1;
    @(posedge clock) stopMode <= 1'b1;
    repeat (5) @(posedge clock);
    cnt(2, 200, n);
    chk(n, 0);
    @(posedge clock);
    rc(`CSU_OFF_STATUS, 8'h02, 8'h00);
    stopMode <= 1'b0;
    poll(8'h02, 8'h02);
    $display("stop test done");
  endtask

  // Higher adjust value must lengthen the internal period
  task automatic t_trim;
    int g, n;
    wr(`CSU_OFF_CTRL_ONE, 8'h3A);
    wr(`CSU_OFF_OSC_ADJUST, 8'h00);
    gap(1, g);
    chk(g, `CSU_IRC_BASE_CYC);
    @(posedge clock);
    wr(`CSU_OFF_OSC_ADJUST, 8'hFF);
    wr(`CSU_OFF_STATUS, 8'h01);
    rc(`CSU_OFF_STATUS, 8'h01, 8'h01);
    rc(`CSU_OFF_OSC_ADJUST, 8'hFF, 8'hFF);
    gap(1, g);
    chk(g, `CSU_IRC_BASE_CYC + 256);
    // Stop enable is 0, so the internal output must stand through a period
    @(posedge clock) stopMode <= 1'b1;
    cnt(1, 3400, n);
    chk(n, 0);
    @(posedge clock) stopMode <= 1'b0;
    $display("adjust test done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_osc();
    t_fbe();
    t_fee();
    t_stop();
    t_trim();
    wrap_up();
  end

  // Watchdog: run needs about 36k cycles
  initial begin
    #900000;
    error_cnt++;
    wrap_up();
  end
endmodule // csu_clock_source_tb
